// file: mat_core_model.sv
// Purpose: Model of the fetch and load/store units that issue translation requests.
// Assumes: The bench calls access() for one request at a time on clk_i.
// Notes: Released request lines show the inverse of the last request, never a stale copy.
`timescale 1ns/1ps
module mat_core_model
   import mat_pkg::*;
(
   input wire logic clk_i,
   input wire mat_xlat_rsp_type xlat_rsp_i,
   input wire logic [1:0] user_prog_outputs_i,
   output mat_xlat_req_type xlat_req_o,
   output logic phys_instr_addressing_o,
   output logic phys_data_addressing_o
);
   // ==========================================================
   // Idle state and request issue
   // ==========================================================
   // Everything starts idle so the block sees no request in reset.
   initial begin
      xlat_req_o = '0;
      phys_instr_addressing_o = 1'b0;
      phys_data_addressing_o = 1'b0;
   end

   // One-cycle request; the answer is read once its edge has settled.
   task automatic access(input mat_xlat_req_type r, input logic instr_phys, input logic data_phys,
                         output mat_xlat_rsp_type rsp, output logic [1:0] pair);
      @(posedge clk_i);
      phys_instr_addressing_o <= instr_phys;
      phys_data_addressing_o <= data_phys;
      xlat_req_o <= r;
      @(posedge clk_i);
      // Inverted fields keep a design that samples late from passing by luck.
      xlat_req_o <= '{valid: 1'b0, vaddr: ~r.vaddr, instr: ~r.instr, store: ~r.store,
                      supervisor: ~r.supervisor, instr_physical_flag: ~r.instr_physical_flag};
      #1;
      rsp = xlat_rsp_i;
      pair = user_prog_outputs_i;
   endtask
endmodule // mat_core_model

// file: mat_pkg.sv
// Purpose: Shared constants and carrier types for the MMU_CONFIGURATION address translation block.
// Assumes: One 100 MHz clock; APB register access with 32-bit data.
// Notes: Printed register numbers are word indices; byte address is four times the index.

package mat_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   // Configuration register index and its byte address.
   localparam logic [11:0] MAT_CFG_INDEX = 12'h000d;
   localparam logic [11:0] MAT_CFG_ADDR = 12'(MAT_CFG_INDEX * 4);
   // Status register holding the outcome of the last translation.
   localparam logic [11:0] MAT_STAT_INDEX = 12'h000e;
   localparam logic [11:0] MAT_STAT_ADDR = 12'(MAT_STAT_INDEX * 4);
   // Translation buffer words: word n sits at MAT_TLB_BASE + 4 * n, n from 0 to 127.
   localparam logic [11:0] MAT_TLB_BASE = 12'h0400;
   localparam logic [2:0] MAT_TLB_SEL = 3'h2;

   // ==========================================================
   // Field layout
   // ==========================================================
   localparam int MAT_PS_HI = 9;
   localparam int MAT_PS_LO = 8;
   localparam logic [31:0] MAT_CFG_MASK = 32'h0000_03ff;
   localparam logic [31:0] MAT_CFG_RESET = 32'h0000_0000;
   localparam int MAT_W0_VALID = 14;
   localparam int MAT_W1_IO = 0;
   localparam int MAT_W1_USAGE = 1;
   // Word 1 keeps the page number, the programmable pair and the space bit.
   localparam logic [31:0] MAT_W1_MASK = 32'hffff_fcc1;
   localparam logic [16:0] MAT_TAG_ALL = 17'h1_ffff;
   localparam logic [31:0] MAT_OFFS_INV = 32'hffff_fc00;
   localparam logic [4:0] MAT_SET_SHIFT = 5'h0a;

   // ==========================================================
   // Trap vectors
   // ==========================================================
   localparam logic [3:0] MAT_VEC_U_IMISS = 4'h8;
   localparam logic [3:0] MAT_VEC_U_DMISS = 4'h9;
   localparam logic [3:0] MAT_VEC_S_IMISS = 4'ha;
   localparam logic [3:0] MAT_VEC_S_DMISS = 4'hb;
   localparam logic [3:0] MAT_VEC_IPROT = 4'hc;
   localparam logic [3:0] MAT_VEC_DPROT = 4'hd;

   // ==========================================================
   // Carrier types
   // ==========================================================
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mat_apb_req_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } mat_apb_rsp_type;

   // One access from the fetch or load/store unit.
   typedef struct packed {
      logic valid;
      logic [31:0] vaddr;
      logic instr;
      logic store;
      logic supervisor;
      logic instr_physical_flag;
   } mat_xlat_req_type;

   // Answer for that access, one cycle later.
   typedef struct packed {
      logic valid;
      logic [31:0] paddr;
      logic io_space;
      logic trap;
      logic [3:0] trap_vec;
   } mat_xlat_rsp_type;

endpackage

// file: mat_tb.sv
// Purpose: Self-checking bench for the address translation block.
// Assumes: APB answers in its own time; each answer is awaited under a bound.
// Notes: Entries are loaded with unused tag and page bits cleared, as software must do.
`timescale 1ns/1ps
module testbench
   import mat_pkg::*;
;
   // ==========================================================
   // Signals and instances
   // ==========================================================
   // Access kinds packed as {instr phys, data phys, fetch, store, supervisor, physical flag}.
   localparam logic [5:0] kind_u_load = 6'h00;
   localparam logic [5:0] kind_u_store = 6'h04;
   localparam logic [5:0] kind_u_fetch = 6'h08;
   localparam logic [5:0] kind_s_load = 6'h02;
   localparam logic [5:0] kind_s_store = 6'h06;
   localparam logic [5:0] kind_s_fetch = 6'h0a;
   logic clk_i = 1'b0;
   logic resetn_i;
   mat_apb_req_type apb_req;
   mat_apb_rsp_type apb_rsp;
   mat_xlat_req_type xlat_req;
   mat_xlat_rsp_type xlat_rsp;
   logic [1:0] prog_pair;
   logic instr_phys;
   logic data_phys;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;

   always #5 clk_i = ~clk_i;

   mat_translate i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .apb_req_i(apb_req), .apb_rsp_o(apb_rsp),
      .phys_instr_addressing_i(instr_phys), .phys_data_addressing_i(data_phys),
      .xlat_req_i(xlat_req), .xlat_rsp_o(xlat_rsp), .user_prog_outputs_o(prog_pair));
   mat_core_model i_core (.clk_i(clk_i), .xlat_rsp_i(xlat_rsp), .user_prog_outputs_i(prog_pair),
      .xlat_req_o(xlat_req), .phys_instr_addressing_o(instr_phys), .phys_data_addressing_o(data_phys));

   // ==========================================================
   // Shared tasks
   // ==========================================================
   // Ends the run; the only place where a verdict is printed.
   task automatic complete_run();
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Compares one value and counts it.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk_i);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk_i);
      apb_req.penable <= 1'b1;
      // Only the bench's cycle guard may end this wait.
      do begin
         @(posedge clk_i);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      // Released lines show the inverse, so a late sample cannot pass by luck.
      apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~wd};
   endtask

   // Plain register write.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask

   // Byte address of buffer word n.
   function automatic logic [11:0] word_addr(input int n);
      return MAT_TLB_BASE + 12'(4 * n);
   endfunction

   // Writes page size and process ident, then lets the lagged copy settle.
   task automatic set_cfg(input int sz, input logic [7:0] ident);
      wr(MAT_CFG_ADDR, (32'(sz) << 8) | 32'(ident));
      @(posedge clk_i);
   endtask

   // One access; eres is {io space, programmable pair, trap vector}.
   task automatic xchk(input logic [5:0] kind, input logic [31:0] va, input logic [31:0] epa,
                       input logic [6:0] eres);
      mat_xlat_rsp_type rsp;
      logic [1:0] pair;
      i_core.access('{valid: 1'b1, vaddr: va, instr: kind[3], store: kind[2], supervisor: kind[1],
                      instr_physical_flag: kind[0]}, kind[5], kind[4], rsp, pair);
      check(rsp.paddr, epa);
      check({23'h0, rsp.valid, rsp.trap, rsp.io_space, pair, rsp.trap_vec},
            {23'h0, 1'b1, eres[3:0] != 4'h0, eres});
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   // Configuration reset value, reserved bits and an unmapped address.
   task automatic test_regs();
      logic [31:0] rd;
      logic err;
      apb(1'b0, MAT_CFG_ADDR, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
      wr(MAT_CFG_ADDR, 32'hffff_ffff);
      apb(1'b0, MAT_CFG_ADDR, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_03ff);
      apb(1'b1, 12'h3f0, 32'hffff_ffff, rd, err);
      check({31'h0, err}, 32'h0000_0001);
   endtask

   // Every page size: set index, tag width, address join, space bit and pair.
   task automatic test_sizes();
      logic [31:0] va;
      logic [31:0] msk;
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] page;
      int n;
      va = 32'ha5a5_6b3c;
      for (int s = 0; s < 4; s++) begin
         msk = (32'h0000_0001 << s) - 32'h0000_0001;
         n = 64 + 2 * int'((va >> (10 + s)) & 32'h0000_001f);
         // Unused low tag and page bits are cleared, as loading software must.
         w0 = (((va >> 15) & ~msk) << 15) | 32'h0000_7f5a;
         page = 32'h002a_bcde & ~msk;
         w1 = (page << 10) | (32'(s) << 6) | 32'(s & 1);
         set_cfg(s, 8'h5a);
         wr(word_addr(n), w0);
         wr(word_addr(n + 1), w1);
         xchk(kind_u_load, va, (page << 10) | (va & ((32'h0000_0400 << s) - 1)),
              {1'(s & 1), 2'(s), 4'h0});
         xchk(kind_s_load, va, va, 7'h0b);
         wr(word_addr(n), w0 & ~32'h0000_4000);
         xchk(kind_u_load, va, va, 7'h09);
      end
   endtask

   // Permissions by mode, usage update and process ident mismatch.
   task automatic test_prot();
      logic [31:0] rd;
      logic err;
      set_cfg(0, 8'h00);
      // Column 0 of set 11: supervisor read and user execute only, task ident zero.
      wr(word_addr(22), 32'h0000_6100);
      wr(word_addr(23), 32'h0004_8cc0);
      xchk(kind_s_load, 32'h0000_2c24, 32'h0004_8c24, 7'h30);
      xchk(kind_s_store, 32'h0000_2c24, 32'h0000_2c24, 7'h0d);
      xchk(kind_s_fetch, 32'h0000_2c24, 32'h0000_2c24, 7'h0c);
      xchk(kind_u_fetch, 32'h0000_2c24, 32'h0004_8c24, 7'h30);
      xchk(kind_u_store, 32'h0000_2c24, 32'h0000_2c24, 7'h0d);
      // Status keeps trap, hit column, hit and vector of that last access.
      apb(1'b0, MAT_STAT_ADDR, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_050d);
      // Column 0 was used last, so the shared bit marks column 1 as least used.
      apb(1'b0, word_addr(23), 32'h0000_0000, rd, err);
      check(rd, 32'h0004_8cc2);
      set_cfg(0, 8'h01);
      xchk(kind_u_load, 32'h0000_2c24, 32'h0000_2c24, 7'h09);
   endtask

   // Untranslated accesses pass through with no check and a low pair.
   task automatic test_pass();
      xchk(kind_u_load | 6'h10, 32'h0000_2c24, 32'h0000_2c24, 7'h00);
      xchk(kind_u_fetch | 6'h20, 32'h0000_2c24, 32'h0000_2c24, 7'h00);
      xchk(kind_s_load | 6'h01, 32'h0000_2c24, 32'h0000_2c24, 7'h00);
   endtask

   // One miss of each kind, on an address that no entry maps.
   task automatic test_miss();
      for (int i = 0; i < 4; i++) begin
         xchk({2'b00, ~1'(i), 1'b0, 1'(i >> 1), 1'b0}, 32'hffff_0000, 32'hffff_0000,
              {3'b000, 4'(8 + i)});
      end
   endtask

   // ==========================================================
   // Main sequence and hang guard
   // ==========================================================
   // Reset for six cycles, then the scenarios in turn.
   initial begin
      apb_req = '0;
      resetn_i = 1'b0;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      test_regs();
      test_sizes();
      test_prot();
      test_pass();
      test_miss();
      complete_run();
   end

   // The whole run needs well under a thousand cycles; a hang stops here.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 5000) begin
         err_count++;
         complete_run();
      end
   end
endmodule // testbench

// file: mat_translate.sv
// Purpose: Virtual to physical address translation with a 64-entry two-column buffer.
// Assumes: Requests come from logic on clk_i; status bits are same-domain levels.
// Notes: Answer arrives one cycle after the request; APB answers with no wait state.
//
// Overview of operation
// - Fetches translate only when instruction-physical bit clear.
// - User data accesses translate only when data-physical clear.
// - Supervisor data translates when instruction flag and data-physical clear.
// - Page-size field bits 9-8 pick 1K-8K.
// - Page-size write governs translations one cycle later.
// - User accesses require task ident equal process ident.
// - Supervisor accesses require task ident zero.
// - Set index shifts with page size.
// - Both column tags compared, masked by page size.
// - Hit requires the entry valid bit set.
// - Physical address joins page number and offset.
// - Entry space bit selects memory or I/O.
// - Hit is checked against mode and access permissions.
// - Valid permitted access goes out, else trap.
// - Programmable pair driven on success, else low.
// - Miss vectors 8-11, instruction protection vector 12.
// - Word 0 holds tag, valid, permissions, task.
// - Word 1 holds page, programmable, usage, space.
// - Every valid hit marks other column least used.
// - Data protection violation raises vector 13.
//
// Our own choice: the APB interface to the registers.

`timescale 1ns/1ps

module mat_translate
   import mat_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire mat_apb_req_type apb_req_i,
   output mat_apb_rsp_type apb_rsp_o,
   input wire logic phys_instr_addressing_i,
   input wire logic phys_data_addressing_i,
   input wire mat_xlat_req_type xlat_req_i,
   output mat_xlat_rsp_type xlat_rsp_o,
   output logic [1:0] user_prog_outputs_o
);

   // ==========================================================
   // State
   // ==========================================================
   // Buffer words; entry index is {column, set}.
   logic [31:0] tlb_w0_ff [64];
   logic [31:0] tlb_w1_ff [64];
   // Usage bit shared by both entries of a set.
   logic [31:0] usage_ff;
   // Configuration register, reserved bits kept at zero.
   logic [31:0] cfg_ff;
   // Page size as seen by translation, lagging the register by a cycle.
   logic [1:0] ps_eff_ff;
   // Outcome of the most recent translation for software to read.
   logic [31:0] stat_ff;
   mat_apb_rsp_type apb_rsp_ff;
   mat_xlat_rsp_type xlat_rsp_ff;
   logic [1:0] user_prog_ff;

   // ==========================================================
   // APB decode
   // ==========================================================
   // Setup phase is where read data is captured; access phase completes.
   wire apb_setup = apb_req_i.psel & ~apb_req_i.penable;
   wire apb_wr = apb_req_i.psel & apb_req_i.penable & apb_rsp_ff.pready & apb_req_i.pwrite;
   wire sel_cfg = (apb_req_i.paddr == MAT_CFG_ADDR);
   wire sel_stat = (apb_req_i.paddr == MAT_STAT_ADDR);
   wire sel_tlb = (apb_req_i.paddr[11:9] == MAT_TLB_SEL) & (apb_req_i.paddr[1:0] == 2'h0);
   // Register number 0-127: bit 0 picks the word, bit 6 the column.
   wire [6:0] tlb_reg = apb_req_i.paddr[8:2];
   wire [5:0] tlb_ent = {tlb_reg[6], tlb_reg[5:1]};
   wire unmapped = ~(sel_cfg | sel_stat | sel_tlb);
   wire [31:0] w1_rd = (tlb_w1_ff[tlb_ent] & MAT_W1_MASK) | (32'(usage_ff[tlb_reg[5:1]]) << MAT_W1_USAGE);
   wire [31:0] tlb_rd = tlb_reg[0] ? w1_rd : tlb_w0_ff[tlb_ent];
   wire [31:0] rd_mux = sel_cfg ? cfg_ff : sel_stat ? stat_ff : sel_tlb ? tlb_rd : 32'h0000_0000;

   // ==========================================================
   // Translation datapath
   // ==========================================================
   // page size select
   wire [1:0] ps = ps_eff_ff;
   wire [7:0] process_ident = cfg_ff[7:0];
   wire [31:0] va_shift = xlat_req_i.vaddr >> (MAT_SET_SHIFT + 5'(ps));
   wire [4:0] set_idx = va_shift[4:0];
   wire [16:0] tag_mask = MAT_TAG_ALL << ps;
   wire [31:0] offs_mask = ~(MAT_OFFS_INV << ps);
   wire sup = xlat_req_i.supervisor;
   logic [1:0] hit;
   logic [31:0] cand_w0 [2];
   logic [31:0] cand_w1 [2];

   // Both columns of the selected set are looked up side by side.
   for (genvar c = 0; c < 2; c++) begin : g_col
      assign cand_w0[c] = tlb_w0_ff[{c[0], set_idx}];
      assign cand_w1[c] = tlb_w1_ff[{c[0], set_idx}];
      wire tag_ok = ((cand_w0[c][31:15] ^ xlat_req_i.vaddr[31:15]) & tag_mask) == 17'h0_0000;
      wire tid_ok = sup ? (cand_w0[c][7:0] == 8'h00) : (cand_w0[c][7:0] == process_ident);
      assign hit[c] = tag_ok & tid_ok & cand_w0[c][MAT_W0_VALID];
   end

   wire translate = xlat_req_i.instr ? ~phys_instr_addressing_i :
                    sup ? (~xlat_req_i.instr_physical_flag & ~phys_data_addressing_i) :
                    ~phys_data_addressing_i;
   wire any_hit = |hit;
   // With two hits the set is misloaded; column 0 is taken, the result is undefined anyway.
   wire hit_col = ~hit[0];
   wire [31:0] hw0 = cand_w0[hit_col];
   wire [31:0] hw1 = cand_w1[hit_col];
   wire [2:0] perm = sup ? hw0[13:11] : hw0[10:8];
   wire allowed = xlat_req_i.instr ? perm[0] : xlat_req_i.store ? perm[1] : perm[2];
   wire [31:0] xl_paddr = ({hw1[31:10], 10'h000} & ~offs_mask) | (xlat_req_i.vaddr & offs_mask);
   wire [3:0] miss_vec = xlat_req_i.instr ? (sup ? MAT_VEC_S_IMISS : MAT_VEC_U_IMISS)
                                          : (sup ? MAT_VEC_S_DMISS : MAT_VEC_U_DMISS);
   wire [3:0] prot_vec = xlat_req_i.instr ? MAT_VEC_IPROT : MAT_VEC_DPROT;
   wire do_xlat = xlat_req_i.valid & translate;
   wire ok_xlat = do_xlat & any_hit & allowed;
   wire upd_usage = do_xlat & any_hit;

   // Next answer, built combinationally.
   mat_xlat_rsp_type nxt_rsp;
   logic [1:0] nxt_user_prog;
   always_comb begin
      nxt_rsp.valid = xlat_req_i.valid;
      nxt_rsp.paddr = xlat_req_i.vaddr;
      nxt_rsp.io_space = 1'b0;
      nxt_rsp.trap = 1'b0;
      nxt_rsp.trap_vec = 4'h0;
      nxt_user_prog = 2'h0;
      if (do_xlat) begin
         if (!any_hit) begin
            nxt_rsp.trap = 1'b1;
            nxt_rsp.trap_vec = miss_vec;
         end else if (!allowed) begin
            nxt_rsp.trap = 1'b1;
            nxt_rsp.trap_vec = prot_vec;
         end else begin
            nxt_rsp.paddr = xl_paddr;
            nxt_rsp.io_space = hw1[MAT_W1_IO];
            nxt_user_prog = hw1[7:6];
         end
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   // Buffer words: loaded only over APB; word 1 reserved bits are dropped on write.
   for (genvar e = 0; e < 64; e++) begin : g_ent
      wire wr_e = apb_wr & sel_tlb & (tlb_ent == 6'(e));
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            tlb_w0_ff[e] <= 32'h0000_0000;
            tlb_w1_ff[e] <= 32'h0000_0000;
         end else if (wr_e && !tlb_reg[0]) begin
            tlb_w0_ff[e] <= apb_req_i.pwdata;
         end else if (wr_e) begin
            tlb_w1_ff[e] <= apb_req_i.pwdata & MAT_W1_MASK;
         end
      end
   end

   // Usage bits: a translation in the same cycle as a software write wins.
   for (genvar s = 0; s < 32; s++) begin : g_set
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            usage_ff[s] <= 1'b0;
         end else if (upd_usage && set_idx == 5'(s)) begin
            usage_ff[s] <= ~hit_col;
         end else if (apb_wr && sel_tlb && tlb_reg[0] && tlb_reg[5:1] == 5'(s)) begin
            usage_ff[s] <= apb_req_i.pwdata[MAT_W1_USAGE];
         end
      end
   end

   // Configuration register and the lagging page size copy.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_ff <= MAT_CFG_RESET;
         ps_eff_ff <= 2'h0;
      end else begin
         if (apb_wr && sel_cfg) begin
            cfg_ff <= apb_req_i.pwdata & MAT_CFG_MASK;
         end
         ps_eff_ff <= cfg_ff[MAT_PS_HI:MAT_PS_LO];
      end
   end

   // Status: bit 8 hit, bit 9 column, bit 10 trap, bits 3-0 last vector.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stat_ff <= 32'h0000_0000;
      end else if (do_xlat) begin
         stat_ff <= {21'h00_0000, nxt_rsp.trap, hit_col, any_hit, 4'h0, nxt_rsp.trap_vec};
      end
   end

   // APB answer: ready one cycle after setup, so the access phase is one cycle long.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         apb_rsp_ff <= '0;
      end else begin
         apb_rsp_ff.pready <= apb_setup;
         apb_rsp_ff.pslverr <= apb_setup & unmapped;
         apb_rsp_ff.prdata <= apb_setup ? rd_mux : 32'h0000_0000;
      end
   end

   // Translation answer and programmable outputs, held for one cycle per request.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xlat_rsp_ff <= '0;
         user_prog_ff <= 2'h0;
      end else begin
         xlat_rsp_ff <= nxt_rsp;
         user_prog_ff <= nxt_user_prog;
      end
   end

   assign apb_rsp_o = apb_rsp_ff;
   assign xlat_rsp_o = xlat_rsp_ff;
   assign user_prog_outputs_o = user_prog_ff;

   // ==========================================================
   // Assertions
   // ==========================================================
   // physical fetch passes
   property p_fetch_phys;
      @(posedge clk_i) disable iff (!resetn_i)
      xlat_req_i.valid && xlat_req_i.instr && phys_instr_addressing_i
      |=> xlat_rsp_ff.paddr == $past(xlat_req_i.vaddr) && !xlat_rsp_ff.trap && !xlat_rsp_ff.io_space;
   endproperty
   a_fetch_phys: assert property (p_fetch_phys) else $error("physical fetch was translated");

   property p_user_phys;
      @(posedge clk_i) disable iff (!resetn_i)
      xlat_req_i.valid && !xlat_req_i.instr && !sup && phys_data_addressing_i
      |=> xlat_rsp_ff.paddr == $past(xlat_req_i.vaddr) && user_prog_ff == 2'h0;
   endproperty
   a_user_phys: assert property (p_user_phys) else $error("physical user data was translated");

   property p_sup_flag;
      @(posedge clk_i) disable iff (!resetn_i)
      xlat_req_i.valid && !xlat_req_i.instr && sup && xlat_req_i.instr_physical_flag
      |=> !xlat_rsp_ff.trap && xlat_rsp_ff.paddr == $past(xlat_req_i.vaddr);
   endproperty
   a_sup_flag: assert property (p_sup_flag) else $error("flagged supervisor access translated");

   property p_ps_lag;
      @(posedge clk_i) disable iff (!resetn_i)
      apb_wr && sel_cfg |=> ##1 ps_eff_ff == $past(apb_req_i.pwdata[MAT_PS_HI:MAT_PS_LO], 2);
   endproperty
   a_ps_lag: assert property (p_ps_lag) else $error("page size did not take effect");

   property p_miss_vec;
      @(posedge clk_i) disable iff (!resetn_i)
      do_xlat && !any_hit && !xlat_req_i.instr && !sup
      |=> xlat_rsp_ff.trap && xlat_rsp_ff.trap_vec == 4'h9 && user_prog_ff == 2'h0;
   endproperty
   a_miss_vec: assert property (p_miss_vec) else $error("user data miss vector wrong");

   property p_trap_quiet;
      @(posedge clk_i) disable iff (!resetn_i)
      xlat_rsp_ff.trap |-> user_prog_ff == 2'h0 && xlat_rsp_ff.valid;
   endproperty
   a_trap_quiet: assert property (p_trap_quiet) else $error("programmable pair driven on trap");

   property p_usage;
      @(posedge clk_i) disable iff (!resetn_i)
      upd_usage |=> usage_ff[$past(set_idx)] == !$past(hit_col);
   endproperty
   a_usage: assert property (p_usage) else $error("usage bit not updated");

   property p_dprot;
      @(posedge clk_i) disable iff (!resetn_i)
      do_xlat && any_hit && !allowed && !xlat_req_i.instr
      |=> xlat_rsp_ff.trap && xlat_rsp_ff.trap_vec == 4'hd;
   endproperty
   a_dprot: assert property (p_dprot) else $error("data protection vector wrong");

   property p_offset_8k;
      @(posedge clk_i) disable iff (!resetn_i)
      ok_xlat && ps == 2'h3
      |=> xlat_rsp_ff.paddr[12:0] == $past(xlat_req_i.vaddr[12:0]) && !xlat_rsp_ff.trap;
   endproperty
   a_offset_8k: assert property (p_offset_8k) else $error("page offset not kept");

   property p_io;
      @(posedge clk_i) disable iff (!resetn_i)
      ok_xlat |=> xlat_rsp_ff.io_space == $past(hw1[MAT_W1_IO]) && user_prog_ff == $past(hw1[7:6]);
   endproperty
   a_io: assert property (p_io) else $error("space bit or pair wrong");

   property p_rsp_valid;
      @(posedge clk_i) disable iff (!resetn_i)
      1'b1 |=> xlat_rsp_ff.valid == $past(xlat_req_i.valid);
   endproperty
   a_rsp_valid: assert property (p_rsp_valid) else $error("answer valid does not follow request");

   property p_sup_tid;
      @(posedge clk_i) disable iff (!resetn_i)
      do_xlat && sup && (!cand_w0[0][MAT_W0_VALID] || cand_w0[0][7:0] != 8'h00)
      && (!cand_w0[1][MAT_W0_VALID] || cand_w0[1][7:0] != 8'h00)
      |=> xlat_rsp_ff.trap && xlat_rsp_ff.trap_vec[3:1] == 3'b101;
   endproperty
   a_sup_tid: assert property (p_sup_tid) else $error("supervisor access hit a nonzero ident");

   property p_user_tid;
      @(posedge clk_i) disable iff (!resetn_i)
      do_xlat && !sup && (!cand_w0[0][MAT_W0_VALID] || cand_w0[0][7:0] != process_ident)
      && (!cand_w0[1][MAT_W0_VALID] || cand_w0[1][7:0] != process_ident)
      |=> xlat_rsp_ff.trap && xlat_rsp_ff.trap_vec[3:1] == 3'b100;
   endproperty
   a_user_tid: assert property (p_user_tid) else $error("user access hit a foreign ident");

   property p_invalid_miss;
      @(posedge clk_i) disable iff (!resetn_i)
      do_xlat && !cand_w0[0][MAT_W0_VALID] && !cand_w0[1][MAT_W0_VALID]
      |=> xlat_rsp_ff.trap && xlat_rsp_ff.trap_vec[3:2] == 2'b10;
   endproperty
   a_invalid_miss: assert property (p_invalid_miss) else $error("invalid entry gave a translation");

   property p_iprot;
      @(posedge clk_i) disable iff (!resetn_i)
      do_xlat && any_hit && !allowed && xlat_req_i.instr
      |=> xlat_rsp_ff.trap && xlat_rsp_ff.trap_vec == 4'hc;
   endproperty
   a_iprot: assert property (p_iprot) else $error("instruction protection vector wrong");

   property p_join_1k;
      @(posedge clk_i) disable iff (!resetn_i)
      ok_xlat && ps == 2'h0
      |=> xlat_rsp_ff.paddr == {$past(hw1[31:10]), $past(xlat_req_i.vaddr[9:0])};
   endproperty
   a_join_1k: assert property (p_join_1k) else $error("small page address join wrong");

   property p_untranslated;
      @(posedge clk_i) disable iff (!resetn_i)
      xlat_req_i.valid && !translate
      |=> !xlat_rsp_ff.trap && !xlat_rsp_ff.io_space && user_prog_ff == 2'h0
      && xlat_rsp_ff.paddr == $past(xlat_req_i.vaddr);
   endproperty
   a_untranslated: assert property (p_untranslated) else $error("untranslated access was altered");

endmodule // mat_translate
